//--- rtl/spi_core_defines.svh
// constants of the serial controller: field resets, depths, timing counts
// What this block does
// - four deep 32-bit transmit queue
// - transmit queue eight deep for 8-16 bit words
// - receive queue four deep, eight for short words
// - queue word loads 32-bit transmit shifter
// - receive shifter assembles word, then queued
// - four stage one-bit skew on each side
// - nine bit divisor makes peripheral clock
// - master drives bus clock, slave takes it
// - role bit chooses master or slave
// - duplex bit picks full or one-line transfer
// - pin directions follow master or slave role
// - select polarity bit sets active level
// - idle bus clock level follows polarity bit
// - edge bits pick launch and sample edges
// - word width field sets bits per word
// - unit flag set after each whole word
// - bit order bit picks lsb or msb first
// - master gap between words set by field
// - gap field resets to three
// - first word starts 1 plus 6 cycles later
// - auto select leads 1, trails 1.5 clocks
`ifndef SPI_CORE_DEFINES_SVH
`define SPI_CORE_DEFINES_SVH
// ============================================
// reset values and depths
`define GAP_RESET 4'h3
`define DIV_RESET 9'h000
`define WIDTH_RESET 5'h08
`define DEPTH_WIDE 4'h4
`define DEPTH_NARROW 4'h8
`define MIN_WIDTH 6'h08
`define NARROW_MAX 6'h10
// ============================================
// timing counts; the HALF counts are in half bus clock periods, the others in whole ones
`define LEAD_PCLK 6'h06
`define LEAD_HALF (`LEAD_PCLK + `LEAD_PCLK)
`define SEL_LEAD_HALF 6'h02
`define SEL_TRAIL_HALF 6'h03
`define AUTO_GAP_MIN 4'h3
`endif

//--- rtl/spi_core_pkg.sv
// types shared by the serial controller
package spi_core_pkg;
  // ============================================
  // configuration captured on a write
  typedef struct packed {
    logic role_slave;
    logic duplex_select;
    logic data_dir;
    logic lsb_first;
    logic [4:0] word_width;
    logic clock_idle_level;
    logic transmit_edge_select;
    logic receive_edge_select;
    logic [3:0] word_gap_length;
    logic select_active_polarity;
    logic auto_select_enable;
    logic select_manual;
    logic [8:0] clk_div;
  } cfg_t;
  // ============================================
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LEAD = 5'h02,
    ST_SHIFT = 5'h04,
    ST_GAP = 5'h08,
    ST_TRAIL = 5'h10
  } state_t;
endpackage

//--- rtl/spi_master_slave_core.sv
// serial master/slave controller with word queues and skew buffers
`timescale 1ns/1ps
`include "spi_core_defines.svh"

// ============================================
// word queue with a run-time depth limit
module spi_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [3:0] limit_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [3:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [3:0] count_reg;
  logic push;
  logic pop;

  // handshakes; full honours the active depth
  assign in_ready_o = (count_reg < limit_i);
  assign out_valid_o = (count_reg != 4'h0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr_reg];
  assign count_o = count_reg;

  // storage write
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= 4'h0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + {3'h0, push} - {3'h0, pop};
    end
  end
endmodule

// ============================================
// controller top
module spi_master_slave_core
  import spi_core_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire cfg_t cfg_i,
  input wire logic cfg_write_i,
  input wire logic [31:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [31:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [3:0] tx_level_o,
  output logic [3:0] rx_level_o,
  output logic busy_o,
  output logic unit_flag_o,
  output logic rx_overrun_o,
  input wire logic status_clr_i,
  input wire logic bus_clock_pin_i,
  output logic bus_clock_pin_o,
  output logic bus_clock_pin_oe_o,
  input wire logic select_pin_i,
  output logic select_pin_o,
  output logic select_pin_oe_o,
  input wire logic data_out_pin_i,
  output logic data_out_pin_o,
  output logic data_out_pin_oe_o,
  input wire logic data_in_pin_i,
  output logic data_in_pin_o,
  output logic data_in_pin_oe_o
);
  // word width field, 0 meaning 32, floored at 8
  function automatic logic [5:0] width_of(input logic [4:0] f);
    if (f == 5'h00) return 6'h20;
    if ({1'b0, f} < `MIN_WIDTH) return `MIN_WIDTH;
    return {1'b0, f};
  endfunction

  // map data bits to stream order and back (self-inverse)
  function automatic logic [31:0] order_bits(input logic [31:0] d,
    input logic [5:0] w, input logic lsb);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      if (lsb) r[i] = d[i];
      else if (i < int'(w)) r[i] = d[int'(w) - 1 - i];
    end
    return r;
  endfunction

  cfg_t cfg_reg;
  state_t state_reg;
  logic [8:0] div_cnt_reg;
  logic [5:0] cnt_reg;
  logic [6:0] edge_cnt_reg;
  logic [5:0] rx_cnt_reg;
  logic [31:0] tx_sh_reg;
  logic [3:0] tx_skew_reg;
  logic [31:0] rx_sh_reg;
  logic [3:0] rx_skew_reg;
  logic sclk_reg;
  logic sel_act_reg;
  logic sel_o_reg;
  logic dout_reg;
  logic rx_push_reg;
  logic unit_reg;
  logic overrun_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;

  // ============================================
  // configuration register, gap field resets to 3 periods
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cfg_reg <= '0;
      cfg_reg.word_width <= `WIDTH_RESET;
      cfg_reg.word_gap_length <= `GAP_RESET;
      cfg_reg.clk_div <= `DIV_RESET;
    end else if (cfg_write_i) begin
      cfg_reg <= cfg_i;
    end
  end

  // ============================================
  // pin synchronisers: clock, select, data out pin, data in pin
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else begin
      sync1_reg <= {data_in_pin_i, data_out_pin_i, select_pin_i,
                    bus_clock_pin_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // ============================================
  // decode of mode, width and depth
  wire is_slave = cfg_reg.role_slave;
  wire half_dpx = cfg_reg.duplex_select;
  wire [5:0] width = width_of(cfg_reg.word_width);
  wire narrow = (width <= `NARROW_MAX);
  wire [3:0] depth = narrow ? `DEPTH_NARROW : `DEPTH_WIDE;
  wire [3:0] gap = cfg_reg.word_gap_length;
  wire [5:0] gap_half = {1'b0, gap, 1'b0};
  wire sel_in_act = (sync2_reg[1] == cfg_reg.select_active_polarity);
  wire sel_in_was = (sync3_reg[1] == cfg_reg.select_active_polarity);
  wire slave_sel = is_slave & sel_in_act;
  wire slave_start = is_slave & sel_in_act & ~sel_in_was;
  wire s_rise = sync2_reg[0] & ~sync3_reg[0];
  wire s_fall = ~sync2_reg[0] & sync3_reg[0];

  // ============================================
  // queues
  logic tx_out_valid;
  logic [31:0] tx_out_data;
  logic rx_in_ready;
  logic load;
  logic [31:0] rx_word;
  spi_word_fifo #(.WIDTH(32), .DEPTH(8)) u_tx_fifo (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .limit_i(depth),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(tx_out_data),
    .out_valid_o(tx_out_valid),
    .out_ready_i(load),
    .count_o(tx_level_o)
  );
  spi_word_fifo #(.WIDTH(32), .DEPTH(8)) u_rx_fifo (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .limit_i(depth),
    .in_data_i(rx_word),
    .in_valid_i(rx_push_reg),
    .in_ready_o(rx_in_ready),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .count_o(rx_level_o)
  );

  // ============================================
  // peripheral clock divider, one tick per half bus clock
  wire half_tick = (div_cnt_reg == cfg_reg.clk_div);
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || state_reg == ST_IDLE || half_tick) div_cnt_reg <= '0;
    else div_cnt_reg <= div_cnt_reg + 9'h001;
  end

  // ============================================
  // edge decode, shared by both roles
  wire m_shift = ~is_slave & (state_reg == ST_SHIFT);
  wire edge_ev = m_shift ? half_tick : (slave_sel & (s_rise | s_fall));
  wire edge_neg = m_shift ? sclk_reg : s_fall;
  wire launch = edge_ev & (edge_neg == cfg_reg.transmit_edge_select) &
                (edge_cnt_reg != 7'h00);
  wire sample = edge_ev & (edge_neg == cfg_reg.receive_edge_select) &
                (rx_cnt_reg < width);
  wire word_done = sample & (rx_cnt_reg == width - 6'h01);
  wire last_edge = edge_ev &
                   (edge_cnt_reg == {width, 1'b0} - 7'h01);
  // receive line: master full duplex uses data in pin
  wire rx_bit = (~is_slave & ~half_dpx) ? sync2_reg[3] : sync2_reg[2];

  // ============================================
  // master word launch conditions
  wire can_go = tx_out_valid & rx_in_ready & ~rx_push_reg;
  wire n_zero = (gap == 4'h0);
  wire m_load_lead = (state_reg == ST_LEAD) & half_tick &
                     (cnt_reg == `LEAD_HALF - 6'h02);
  wire m_load_b2b = m_shift & last_edge & n_zero & can_go;
  wire m_load_gap = (state_reg == ST_GAP) & half_tick & can_go &
                    (cnt_reg >= gap_half - 6'h01);
  wire m_load = ~is_slave & (m_load_lead | m_load_b2b | m_load_gap);
  wire s_load = slave_start | (slave_sel & word_done);
  wire word_load = m_load | s_load;
  assign load = word_load & tx_out_valid;
  // empty queue in slave mode shifts out zeros
  wire [31:0] stream = order_bits(load ? tx_out_data : 32'h0,
                                  width, cfg_reg.lsb_first);
  assign rx_word = order_bits(rx_sh_reg, width, cfg_reg.lsb_first);

  // ============================================
  // master sequencer
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || is_slave) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 6'h00;
          if (can_go) state_reg <= ST_LEAD;
        end
        ST_LEAD: begin
          if (half_tick) cnt_reg <= cnt_reg + 6'h01;
          if (m_load_lead) state_reg <= ST_SHIFT;
        end
        ST_SHIFT: begin
          cnt_reg <= 6'h00;
          if (last_edge && !m_load_b2b) begin
            state_reg <= tx_out_valid ? ST_GAP : ST_TRAIL;
          end
        end
        ST_GAP: begin
          if (half_tick && cnt_reg != 6'h3f) cnt_reg <= cnt_reg + 6'h01;
          if (m_load_gap) state_reg <= ST_SHIFT;
        end
        ST_TRAIL: begin
          if (half_tick) cnt_reg <= cnt_reg + 6'h01;
          if (half_tick && cnt_reg == `SEL_TRAIL_HALF - 6'h01) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ============================================
  // auto select timing: lead one clock, trail one and a half
  wire sel_on = half_tick & (
    ((state_reg == ST_LEAD) &
     (cnt_reg == `LEAD_HALF - `SEL_LEAD_HALF - 6'h01)) |
    ((state_reg == ST_GAP) & (cnt_reg == gap_half - `SEL_LEAD_HALF)));
  wire sel_off = half_tick & (cnt_reg == `SEL_TRAIL_HALF - 6'h01) & (
    (state_reg == ST_TRAIL) |
    ((state_reg == ST_GAP) & (gap >= `AUTO_GAP_MIN)));
  wire sel_act = cfg_reg.auto_select_enable ? sel_act_reg :
                 cfg_reg.select_manual;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || is_slave) sel_act_reg <= 1'b0;
    else if (sel_on) sel_act_reg <= 1'b1;
    else if (sel_off) sel_act_reg <= 1'b0;
  end

  // ============================================
  // bus clock generation, idles at configured level
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) sclk_reg <= 1'b0;
    else if (!m_shift) sclk_reg <= cfg_reg.clock_idle_level;
    else if (half_tick) sclk_reg <= ~sclk_reg;
  end

  // ============================================
  // edge and bit counters
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || word_load || (is_slave && !slave_sel)) begin
      edge_cnt_reg <= 7'h00;
      rx_cnt_reg <= 6'h00;
    end else begin
      if (edge_ev) edge_cnt_reg <= edge_cnt_reg + 7'h01;
      if (sample) rx_cnt_reg <= rx_cnt_reg + 6'h01;
    end
  end

  // ============================================
  // transmit shifter and skew buffer
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tx_sh_reg <= 32'h0;
      tx_skew_reg <= 4'h0;
      dout_reg <= 1'b0;
    end else if (word_load) begin
      dout_reg <= stream[0];
      tx_skew_reg <= stream[4:1];
      tx_sh_reg <= {5'h00, stream[31:5]};
    end else if (launch) begin
      dout_reg <= tx_skew_reg[0];
      tx_skew_reg <= {tx_sh_reg[0], tx_skew_reg[3:1]};
      tx_sh_reg <= {1'b0, tx_sh_reg[31:1]};
    end
  end

  // ============================================
  // receive skew buffer and shifter, word pushed when complete
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rx_sh_reg <= 32'h0;
      rx_skew_reg <= 4'h0;
      rx_push_reg <= 1'b0;
    end else begin
      rx_push_reg <= word_done;
      if (word_load && !sample) begin
        rx_sh_reg <= 32'h0;
      end else if (sample) begin
        rx_skew_reg <= {rx_skew_reg[2:0], rx_bit};
        rx_sh_reg[rx_cnt_reg[4:0]] <= rx_bit;
      end
    end
  end

  // ============================================
  // sticky status, a set beats a clear in the same cycle
  wire overrun_set = rx_push_reg & ~rx_in_ready;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      unit_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      unit_reg <= rx_push_reg | (unit_reg & ~status_clr_i);
      overrun_reg <= overrun_set | (overrun_reg & ~status_clr_i);
    end
  end

  // ============================================
  // select pin output level from polarity
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) sel_o_reg <= 1'b1; // inactive for reset polarity
    else sel_o_reg <= sel_act ~^ cfg_reg.select_active_polarity;
  end

  // ============================================
  // pin drive and directions
  wire tx_line = ~half_dpx | cfg_reg.data_dir;
  assign bus_clock_pin_o = sclk_reg;
  assign bus_clock_pin_oe_o = ~is_slave;
  assign select_pin_o = sel_o_reg;
  assign select_pin_oe_o = ~is_slave;
  assign data_out_pin_o = dout_reg;
  assign data_out_pin_oe_o = is_slave ? (half_dpx & cfg_reg.data_dir &
                             slave_sel) : tx_line;
  assign data_in_pin_o = dout_reg;
  assign data_in_pin_oe_o = slave_sel & ~half_dpx;
  assign busy_o = (state_reg != ST_IDLE) | tx_out_valid | slave_sel;
  assign unit_flag_o = unit_reg;
  assign rx_overrun_o = overrun_reg;
endmodule

//--- tb/spi_core_props.sv
// assertion checker on the controller top ports
`timescale 1ns/1ps
module spi_core_props
  import spi_core_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire cfg_t cfg_i,
  input wire logic cfg_write_i,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic [3:0] tx_level_o,
  input wire logic busy_o,
  input wire logic unit_flag_o,
  input wire logic status_clr_i,
  input wire logic bus_clock_pin_o,
  input wire logic bus_clock_pin_oe_o,
  input wire logic select_pin_o,
  input wire logic data_in_pin_oe_o
);
  // ====
  // shadow configuration and lead counter
  cfg_t cfg_reg;
  logic first_reg;
  logic [9:0] lead_reg;
  wire [4:0] wd = cfg_reg.word_width;
  wire [3:0] depth = (wd != 5'h00 && wd <= 5'h10) ? 4'h8 : 4'h4;
  wire [9:0] half = {1'b0, cfg_reg.clk_div} + 10'h001;
  wire active = select_pin_o == cfg_reg.select_active_polarity;
  wire master = !cfg_reg.role_slave;
  wire at_idle = bus_clock_pin_o == cfg_reg.clock_idle_level;
  // capture configuration on a write
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cfg_reg <= {4'h0, 5'h08, 3'h0, 4'h3, 3'h0, 9'h000};
    end else if (cfg_write_i) begin
      cfg_reg <= cfg_i;
    end
  end
  // cycles from busy rising to the first bus clock edge
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !busy_o) begin
      first_reg <= 1'b1;
      lead_reg <= 10'h000;
    end else if (!at_idle) begin
      first_reg <= 1'b0;
    end else if (first_reg) begin
      lead_reg <= lead_reg + 10'h001;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // ====
  // assertions
  a_tx_depth: assert property (tx_level_o <= depth)
    else $error("tx queue above depth");
  a_tx_refuse: assert property (!tx_ready_o |-> tx_level_o == depth)
    else $error("tx refused below depth");
  a_push_busy: assert property (tx_valid_i && tx_ready_o |=> busy_o)
    else $error("push left core idle");
  a_master_pins: assert property (bus_clock_pin_oe_o == master)
    else $error("clock pin direction wrong");
  a_master_miso: assert property (master |-> !data_in_pin_oe_o)
    else $error("master drives input line");
  a_clock_idle: assert property (!busy_o && !$past(busy_o) && master &&
    !$past(cfg_write_i) |-> at_idle) else $error("clock not at idle level");
  a_select_idle: assert property (!busy_o && !$past(busy_o) && master &&
    cfg_reg.auto_select_enable && !$past(cfg_write_i) |-> !active)
    else $error("select active while idle");
  a_select_lead: assert property ($rose(active) && master &&
    cfg_reg.auto_select_enable && !$past(cfg_write_i)
    |=> $stable(bus_clock_pin_o)[*5]) else $error("select lead too short");
  a_lead_time: assert property (master && busy_o && first_reg && !at_idle
    |-> lead_reg >= half * 10'h00b && lead_reg <= half * 10'h00d + 10'h004)
    else $error("first clock edge off time");
  a_unit_sticky: assert property (unit_flag_o && !status_clr_i
    |=> unit_flag_o) else $error("unit flag dropped");
  c_refused: cover property (!tx_ready_o);
  c_word_done: cover property ($rose(unit_flag_o));
  c_select: cover property ($rose(active) && master);
endmodule

bind spi_master_slave_core spi_core_props u_spi_core_props (.*);

//--- tb/spi_master_slave_core_tb.sv
// self-checking bench: core as master against a slave model, then as slave against driven pins
`timescale 1ns/1ps
module spi_master_slave_core_tb;
  import spi_core_pkg::*;
  // ====
  // signals
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  cfg_t cfg_i = '0;
  logic cfg_write_i = 1'b0;
  logic [31:0] tx_data_i = 32'h0;
  logic tx_valid_i = 1'b0;
  logic rx_ready_i = 1'b0;
  logic status_clr_i = 1'b0;
  logic tx_ready_o, rx_valid_o, busy_o, unit_flag_o, rx_overrun_o;
  logic bus_clock_pin_o, bus_clock_pin_oe_o, select_pin_o, select_pin_oe_o;
  logic data_out_pin_o, data_out_pin_oe_o, data_in_pin_o, data_in_pin_oe_o;
  logic [31:0] rx_data_o, got;
  logic [3:0] tx_level_o, rx_level_o;
  logic [31:0] exp_rx[$], exp_tx[$];
  logic [5:0] w = 6'h20;
  logic lsbq = 1'b0;
  logic polq = 1'b0;
  logic miso_m;
  // off-chip master levels, used while the core is a slave
  logic ext_sclk = 1'b0;
  logic ext_sel = 1'b1;
  logic ext_mosi = 1'b1;
  int got_cnt, k = 0, seed = 32'hbb77;
  int miscompares = 0;
  int total_checks = 0;
  // wire levels from every driver's enable
  wire bus_clock_pin_i = bus_clock_pin_oe_o ? bus_clock_pin_o : ext_sclk;
  wire select_pin_i = select_pin_oe_o ? select_pin_o : ext_sel;
  wire data_out_pin_i = data_out_pin_oe_o ? data_out_pin_o : ext_mosi;
  wire model_sel = select_pin_oe_o ? select_pin_o : ~polq;
  wire data_in_pin_i = data_in_pin_oe_o ? data_in_pin_o : miso_m;
  always #50 mclk_i = ~mclk_i;
  spi_master_slave_core u_spi_master_slave_core (.*);
  spi_slave_model u_spi_slave_model (.mclk_i(mclk_i),
    .sclk_i(bus_clock_pin_i), .sel_i(model_sel), .pol_i(polq),
    .lsb_i(lsbq), .width_i(w), .mosi_i(data_out_pin_i), .miso_o(miso_m),
    .got_o(got), .got_cnt_o(got_cnt));
  // ====
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] msk();
    return 32'((33'h1 << w) - 33'h1);
  endfunction
  // queue one word, noting what both ends should see
  task automatic push(input logic [31:0] d, input logic [31:0] depth);
    int n;
    n = 0;
    tx_data_i = d;
    tx_valid_i = 1'b1;
    @(negedge mclk_i);
    while (tx_ready_o !== 1'b1 && n < 5000) begin
      if (n == 0) chk("tx_level", 32'(tx_level_o), depth);
      n++;
      @(negedge mclk_i);
    end
    if (n == 5000) begin
      miscompares++;
      give_verdict();
    end
    exp_tx.push_back(d & msk());
    exp_rx.push_back((32'h5ac3_96e1 ^ (32'(k) * 32'h0101_0101)) & msk());
    k++;
    @(posedge mclk_i);
    #2;
  endtask
  // configure, send a burst, wait for idle, check levels and flag
  task automatic run(input logic [4:0] wd, input logic lsb, idl,
      input logic [3:0] gap, input logic pol, input int n);
    int i;
    cfg_i = {3'h1, lsb, wd, idl, 2'h2, gap, pol, 2'h2, 9'h003};
    cfg_write_i = 1'b1;
    w = (wd == 5'h00) ? 6'h20 : (wd < 5'h08) ? 6'h08 : {1'b0, wd};
    lsbq = lsb;
    polq = pol;
    @(posedge mclk_i);
    #2;
    cfg_write_i = 1'b0;
    for (i = 0; i < n; i++)
      push($random(seed), (w <= 6'h10) ? 32'h8 : 32'h4);
    tx_valid_i = 1'b0;
    for (i = 0; i < 20000 && (busy_o !== 1'b0 || exp_rx.size() > 0); i++)
      @(negedge mclk_i);
    if (i == 20000) begin
      miscompares++;
      give_verdict();
    end
    @(negedge mclk_i);
    chk("unit_flag", 32'(unit_flag_o), 32'h1);
    chk("clock_idle", 32'(bus_clock_pin_o), 32'(idl));
    chk("select_idle", 32'(select_pin_o), 32'(!pol));
    chk("overrun", 32'(rx_overrun_o), 32'h0);
    chk("busy", 32'(busy_o), 32'h0);
    chk("levels", {24'h0, tx_level_o, rx_level_o}, 32'h0);
    chk("dout_oe", 32'(data_out_pin_oe_o), 32'h1);
    chk("din_oe", 32'(data_in_pin_oe_o), 32'h0);
    chk("sel_oe", 32'(select_pin_oe_o), 32'h1);
    status_clr_i = 1'b1;
    @(posedge mclk_i);
    #2;
    status_clr_i = 1'b0;
    @(negedge mclk_i);
    chk("unit_clear", 32'(unit_flag_o), 32'h0);
  endtask
  // core as slave: one 8-bit word each way, msb first
  task automatic slave_word(input logic [7:0] d, input logic [7:0] m);
    logic [7:0] seen;
    int i;
    @(posedge mclk_i);
    #2;
    cfg_i = {4'h8, 5'h08, 1'b0, 2'h2, 4'h3, 1'b0, 2'h0, 9'h003};
    cfg_write_i = 1'b1;
    @(posedge mclk_i);
    #2;
    cfg_write_i = 1'b0;
    tx_data_i = {24'h0, d};
    tx_valid_i = 1'b1;
    @(posedge mclk_i);
    #2;
    tx_valid_i = 1'b0;
    exp_rx.push_back({24'h0, m});
    chk("slave_clk_oe", 32'(bus_clock_pin_oe_o), 32'h0);
    ext_sel = 1'b0;
    for (i = 0; i < 8; i++) begin
      ext_mosi = m[7 - i];
      repeat (6) @(posedge mclk_i);
      #2;
      seen[7 - i] = data_in_pin_i;
      ext_sclk = 1'b1;
      repeat (6) @(posedge mclk_i);
      #2;
      ext_sclk = 1'b0;
    end
    chk("slave_din_oe", 32'(data_in_pin_oe_o), 32'h1);
    repeat (6) @(posedge mclk_i);
    #2;
    ext_sel = 1'b1;
    repeat (6) @(posedge mclk_i);
    #2;
    chk("slave_tx", {24'h0, seen}, {24'h0, d});
    for (i = 0; i < 500 && (busy_o !== 1'b0 || exp_rx.size() > 0); i++)
      @(negedge mclk_i);
    if (i == 500) begin
      miscompares++;
      give_verdict();
    end
    chk("slave_unit", 32'(unit_flag_o), 32'h1);
  endtask
  // take received words at a random pace and compare
  always @(posedge mclk_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
      chk("rx_word", rx_data_o, exp_rx.pop_front());
    #2;
    rx_ready_i = 1'($random(seed));
  end
  // words seen by the slave model
  always @(got_cnt)
    chk("slave_word", got, exp_tx.pop_front());
  // main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    #2;
    rstn_i = 1'b1;
    @(negedge mclk_i);
    chk("tx_ready", 32'(tx_ready_o), 32'h1);
    chk("rx_valid", 32'(rx_valid_o), 32'h0);
    chk("clock_oe", 32'(bus_clock_pin_oe_o), 32'h1);
    chk("select", 32'(select_pin_o), 32'h1);
    run(5'h08, 1'b0, 1'b0, 4'h0, 1'b0, 12);
    run(5'h00, 1'b1, 1'b1, 4'h3, 1'b1, 6);
    run(5'h10, 1'b1, 1'b0, 4'hf, 1'b0, 10);
    run(5'h03, 1'b0, 1'b1, 4'h1, 1'b0, 3);
    repeat (2) slave_word(8'($random(seed)), 8'($random(seed)));
    give_verdict();
  end
endmodule

//--- tb/spi_slave_model.sv
// off-chip slave device model answering numbered words
`timescale 1ns/1ps
module spi_slave_model (
  input wire logic mclk_i,
  input wire logic sclk_i,
  input wire logic sel_i,
  input wire logic pol_i,
  input wire logic lsb_i,
  input wire logic [5:0] width_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic [31:0] got_o,
  output int got_cnt_o
);
  // ====
  // bit counters and reply word
  int cnt = 0;
  int seq = 0;
  logic [31:0] sr = 32'h0;
  wire act = sel_i == pol_i;
  initial miso_o = 1'b0;
  initial got_cnt_o = 0;
  function automatic logic pick(input int c);
    logic [31:0] r;
    r = 32'h5ac3_96e1 ^ (32'(seq) * 32'h0101_0101);
    return r[lsb_i ? c : int'(width_i) - 1 - c];
  endfunction
  // first bit on select, restart counting on release
  always @(act) begin
    cnt = 0;
    if (act) miso_o = pick(0);
  end
  // sample on rising edges, hand each whole word on
  always @(posedge sclk_i) begin
    if (act) begin
      sr = lsb_i ? {mosi_i, sr[31:1]} : {sr[30:0], mosi_i};
      cnt++;
      if (cnt == int'(width_i)) begin
        got_o = lsb_i ? sr >> (32 - int'(width_i))
          : sr & 32'((33'h1 << width_i) - 33'h1);
        got_cnt_o++;
        seq++;
        cnt = 0;
      end
    end
  end
  // launch the next bit on falling edges
  always @(negedge sclk_i) begin
    if (act) miso_o = pick(cnt);
  end
  // released line shows no stale data
  always @(posedge mclk_i) begin
    if (!act) miso_o = ~miso_o;
  end
endmodule
